// ===== hw/mfsc_regs.vh
// Purpose: constants for the memory fault status capture block
// Assumes: 32-bit address space, 8-bit status byte
// Notes:   offsets are word addresses on the plain register port
`ifndef MFSC_REGS_VH
`define MFSC_REGS_VH
`define MFSC_OFF_STATUS      4'h0
`define MFSC_OFF_ADDR        4'h1
`define MFSC_OFF_IRQ_STATUS  4'h2
`define MFSC_OFF_IRQ_MASK    4'h3
`define MFSC_BIT_FETCH       0
`define MFSC_BIT_DATA        1
`define MFSC_BIT_RSVD        2
`define MFSC_BIT_POP         3
`define MFSC_BIT_PUSH        4
`define MFSC_BIT_VALID       7
`define MFSC_STATUS_RESET    8'h00
`define MFSC_ADDR_RESET      32'h0000_0000
`define MFSC_MASK_RESET      8'h00
`endif

// ===== hw/mfsc_flag.v
// Purpose: one sticky write-one-to-clear status flag
// Assumes: set and clear are single-cycle pulses on clk
// Notes:   set wins over a clear in the same cycle
`timescale 1ns/1ps
module mfsc_flag (
    // clock and reset
    input  wire clk,
    input  wire rst_b,
    // control
    input  wire set,
    input  wire clr,
    // state
    output reg  flag
);
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flag <= 1'b0;
        end else if (set) begin
            flag <= 1'b1;
        end else if (clr) begin
            flag <= 1'b0;
        end
    end
endmodule // mfsc_flag

// ===== hw/mfsc_irq.v
// Purpose: sticky event status cleared on read, mask, level interrupt
// Assumes: events are single-cycle pulses
// Notes:   an event in the reading cycle survives the clear
`timescale 1ns/1ps
module mfsc_irq #(
    parameter W = 8
) (
    // clock and reset
    input  wire         clk,
    input  wire         rst_b,
    // events and control
    input  wire [W-1:0] event_in,
    input  wire         rd_clear,
    input  wire         mask_we,
    input  wire [W-1:0] mask_wdata,
    // state
    output reg  [W-1:0] status,
    output reg  [W-1:0] mask,
    output wire         irq
);
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            status <= {W{1'b0}};
            mask   <= {W{1'b0}};
        end else begin
            status <= (rd_clear ? {W{1'b0}} : status) | event_in;
            if (mask_we) begin
                mask <= mask_wdata;
            end
        end
    end
    assign irq = |(status & mask);
endmodule // mfsc_irq

// ===== hw/mfsc_top.v
// Summary of operation
// - stacking fault on entry sets bit 4
// - push fault: adjust pointer, no address capture
// - unstacking fault on return sets bit 3
// - pop fault: chain, keep stack, no capture
// - forbidden load or store sets bit 1
// - data fault: faulting pc, capture address
// - fetch from non-executable place sets bit 0
// - execute-never fetch faults even unit disabled
// - fetch fault: faulting pc, no capture
// - flags reset zero, clear on written one
// - bit 2 reserved, reads zero, read-only
// - bit 7 marks captured address valid
//
// Purpose: memory protection fault status byte with address capture
// Assumes: core signals are synchronous to clk, one-cycle pulses
//          checker verdicts arrive in the cycle of their request
// Notes:   core control outputs are combinational decisions
//          reserved bits 2, 5 and 6 ignore writes and read zero
//          several causes in one cycle each set their own flag
//          the address register is only ever loaded by a data fault
`timescale 1ns/1ps
`include "mfsc_regs.vh"
module mfsc_top (
    // clock and reset
    input  wire        clk,
    input  wire        rst_b,
    // register port
    input  wire [3:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    // protection checker and core events
    input  wire        unit_enable,
    input  wire        fetch_req,
    input  wire        fetch_no_exec,
    input  wire        fetch_execute_never,
    input  wire        data_req,
    input  wire        data_forbidden,
    input  wire [31:0] data_address,
    input  wire        push_req,
    input  wire        push_fault,
    input  wire        pop_req,
    input  wire        pop_fault,
    // decisions back to the core
    output wire        fault_taken,
    output wire        pc_at_faulting,
    output wire        sp_adjust,
    output wire        chain_to_handler,
    output wire        skip_context_save,
    output wire        context_suspect,
    // interrupt
    output wire        irq
);
    // decoded register accesses
    wire        wr_status;
    wire        rd_irq_status;
    wire        wr_irq_mask;

    // qualified checker verdicts
    wire        fetch_never_hit;
    wire        fetch_perm_hit;
    wire        fetch_event;
    wire        data_event;
    wire        push_event;
    wire        pop_event;
    wire [3:0]  fault_cause;

    // flag state in status byte layout
    reg  [7:0]  flag_set;
    reg  [7:0]  flag_clr;
    wire [7:0]  flag_q;
    reg  [7:0]  status_byte;

    // interrupt state
    reg  [7:0]  irq_event;
    wire [7:0]  irq_status;
    wire [7:0]  irq_mask;

    // fault address capture
    reg  [31:0] fault_address_capture;
    reg  [31:0] next_fault_address_capture;

    // core decisions
    reg         decide_fault;
    reg         decide_pc;
    reg         decide_sp;
    reg         decide_chain;
    reg         decide_skip;
    reg         decide_suspect;

    // read path: zero-extended views of each register
    wire [31:0] view_status;
    wire [31:0] view_addr;
    wire [31:0] view_irq_status;
    wire [31:0] view_irq_mask;
    reg  [31:0] next_reg_rdata;

    // number of positions in the status byte
    localparam NFLAGS = 8;

    // writable bits of the status byte; the rest are reserved
    localparam [7:0] LIVE_MASK = (8'h01 << `MFSC_BIT_FETCH) | (8'h01 << `MFSC_BIT_DATA)
                               | (8'h01 << `MFSC_BIT_POP) | (8'h01 << `MFSC_BIT_PUSH)
                               | (8'h01 << `MFSC_BIT_VALID);

    // register indices on the plain port
    localparam [3:0] IDX_STATUS     = `MFSC_OFF_STATUS;
    localparam [3:0] IDX_ADDR       = `MFSC_OFF_ADDR;
    localparam [3:0] IDX_IRQ_STATUS = `MFSC_OFF_IRQ_STATUS;
    localparam [3:0] IDX_IRQ_MASK   = `MFSC_OFF_IRQ_MASK;

    // register port decode; writes to other indices are ignored
    assign wr_status     = reg_wr & (reg_addr == IDX_STATUS);
    assign rd_irq_status = reg_rd & (reg_addr == IDX_IRQ_STATUS);
    assign wr_irq_mask   = reg_wr & (reg_addr == IDX_IRQ_MASK);

    // execute-never is checked regardless of unit_enable
    assign fetch_never_hit = fetch_req & fetch_execute_never;
    assign fetch_perm_hit  = fetch_req & unit_enable & fetch_no_exec;
    assign fetch_event     = fetch_never_hit | fetch_perm_hit;
    assign data_event      = data_req & unit_enable & data_forbidden;
    assign push_event      = push_req & unit_enable & push_fault;
    assign pop_event       = pop_req & unit_enable & pop_fault;

    // any one cause is enough for the core to take the fault
    assign fault_cause = {pop_event, push_event, data_event, fetch_event};

    // several causes may land in one cycle; each keeps its own flag
    always @* begin
        flag_set                  = 8'h00;
        flag_set[`MFSC_BIT_FETCH] = fetch_event;
        flag_set[`MFSC_BIT_DATA]  = data_event;
        flag_set[`MFSC_BIT_POP]   = pop_event;
        flag_set[`MFSC_BIT_PUSH]  = push_event;
        flag_set[`MFSC_BIT_VALID] = data_event;
    end

    // write-one-to-clear; zeros and reserved bits leave flags alone
    always @* begin
        flag_clr = 8'h00;
        if (wr_status) begin
            flag_clr = reg_wdata[7:0] & LIVE_MASK;
        end
    end

    // one sticky flag per live bit; set beats a clear in the same cycle
    genvar i;

    generate
        for (i = 0; i < NFLAGS; i = i + 1) begin : g_flag
            if (LIVE_MASK[i] == 1'b1) begin : g_live
                mfsc_flag u_flag (
                    .clk   (clk),
                    .rst_b (rst_b),
                    .set   (flag_set[i]),
                    .clr   (flag_clr[i]),
                    .flag  (flag_q[i])
                );
            end else begin : g_rsvd
                assign flag_q[i] = 1'b0;
            end
        end
    endgenerate

    // reserved positions read as zero whatever was written
    always @* begin
        status_byte = flag_q & LIVE_MASK;
    end

    // only data faults load the address; other causes keep the old value
    always @* begin
        next_fault_address_capture = fault_address_capture;
        if (data_event) begin
            next_fault_address_capture = data_address;
        end
    end

    // stacking, unstacking and fetch faults leave the address alone
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fault_address_capture <= `MFSC_ADDR_RESET;
        end else begin
            fault_address_capture <= next_fault_address_capture;
        end
    end

    // decisions are combinational so the core can act in the access cycle
    always @* begin
        decide_fault = |fault_cause;
        decide_pc    = 1'b0;
        if (fetch_event) begin
            decide_pc = 1'b1;
        end
        if (data_event) begin
            decide_pc = 1'b1;
        end
    end

    // a faulty push still moves the pointer; a faulty pop must not
    always @* begin
        decide_sp = 1'b0;
        if (push_req) begin
            decide_sp = 1'b1;
        end
        if (pop_event) begin
            decide_sp = 1'b0;
        end
    end

    // a pop fault chains straight on and leaves the old frame in place
    always @* begin
        decide_chain = 1'b0;
        decide_skip  = 1'b0;
        if (pop_event) begin
            decide_chain = 1'b1;
            decide_skip  = 1'b1;
        end
    end

    // the frame written by a faulty push may hold wrong values
    always @* begin
        decide_suspect = 1'b0;
        if (push_event) begin
            decide_suspect = 1'b1;
        end
    end

    // decision outputs
    assign fault_taken       = decide_fault;
    assign pc_at_faulting    = decide_pc;
    assign sp_adjust         = decide_sp;
    assign chain_to_handler  = decide_chain;
    assign skip_context_save = decide_skip;
    assign context_suspect   = decide_suspect;

    // interrupt events share the status layout; address-valid has no event
    always @* begin
        irq_event                  = 8'h00;
        irq_event[`MFSC_BIT_FETCH] = fetch_event;
        irq_event[`MFSC_BIT_DATA]  = data_event;
        irq_event[`MFSC_BIT_POP]   = pop_event;
        irq_event[`MFSC_BIT_PUSH]  = push_event;
    end

    // the interrupt side keeps its own copy, cleared by reading it
    mfsc_irq #(
        .W (8)
    ) u_irq (
        .clk        (clk),
        .rst_b      (rst_b),
        .event_in   (irq_event),
        .rd_clear   (rd_irq_status),
        .mask_we    (wr_irq_mask),
        .mask_wdata (reg_wdata[7:0]),
        .status     (irq_status),
        .mask       (irq_mask),
        .irq        (irq)
    );

    // byte registers sit in the low bits of the read word
    assign view_status     = {24'h00_0000, status_byte};
    assign view_addr       = fault_address_capture;
    assign view_irq_status = {24'h00_0000, irq_status};
    assign view_irq_mask   = {24'h00_0000, irq_mask};

    // read data stands one cycle after the strobe; unmapped reads zero
    always @* begin
        next_reg_rdata = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                IDX_STATUS: begin
                    next_reg_rdata = view_status;
                end
                IDX_ADDR: begin
                    next_reg_rdata = view_addr;
                end
                IDX_IRQ_STATUS: begin
                    next_reg_rdata = view_irq_status;
                end
                IDX_IRQ_MASK: begin
                    next_reg_rdata = view_irq_mask;
                end
                default: begin
                    next_reg_rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // holding zero outside the answer cycle keeps stale data off the bus
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= next_reg_rdata;
        end
    end
endmodule // mfsc_top

// ===== verification/mfsc_properties.sv
// Purpose: port checks on the core decisions
// Assumes: one clock, one-cycle core pulses
// Notes: decisions are combinational with the request
`timescale 1ns/1ps
module mfsc_props (
    // clock and reset
    input wire clk,
    input wire rst_b,
    // requests and checker verdicts
    input wire unit_enable,
    input wire fetch_req,
    input wire fetch_no_exec,
    input wire fetch_execute_never,
    input wire data_req,
    input wire data_forbidden,
    input wire push_req,
    input wire push_fault,
    input wire pop_req,
    input wire pop_fault,
    // core decisions
    input wire fault_taken,
    input wire pc_at_faulting,
    input wire sp_adjust,
    input wire chain_to_handler,
    input wire skip_context_save,
    input wire context_suspect
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire pushf = push_req && unit_enable && push_fault;
    wire popf  = pop_req && unit_enable && pop_fault;
    a_fetch_fault: assert property (fetch_req && unit_enable && fetch_no_exec |-> fault_taken && pc_at_faulting)
        else $error("fetch fault not taken");
    a_exec_never_fetch: assert property (fetch_req && fetch_execute_never && !unit_enable |-> fault_taken)
        else $error("execute-never fetch missed");
    a_data_fault: assert property (data_req && unit_enable && data_forbidden |-> fault_taken && pc_at_faulting)
        else $error("data fault not taken");
    a_push_sp: assert property (push_req && !popf |-> sp_adjust)
        else $error("stack pointer not adjusted");
    a_push_ctx: assert property (pushf |-> context_suspect)
        else $error("context not marked suspect");
    a_ctx_clean: assert property (!pushf |-> !context_suspect)
        else $error("context marked without fault");
    a_pop_chain: assert property (popf |-> chain_to_handler && skip_context_save && !sp_adjust)
        else $error("pop fault not chained");
    a_no_chain: assert property (!popf |-> !chain_to_handler && !skip_context_save)
        else $error("chain without pop fault");
endmodule // mfsc_props
bind mfsc_top mfsc_props u_props (
    .clk                 (clk),
    .rst_b               (rst_b),
    .unit_enable         (unit_enable),
    .fetch_req           (fetch_req),
    .fetch_no_exec       (fetch_no_exec),
    .fetch_execute_never (fetch_execute_never),
    .data_req            (data_req),
    .data_forbidden      (data_forbidden),
    .push_req            (push_req),
    .push_fault          (push_fault),
    .pop_req             (pop_req),
    .pop_fault           (pop_fault),
    .fault_taken         (fault_taken),
    .pc_at_faulting      (pc_at_faulting),
    .sp_adjust           (sp_adjust),
    .chain_to_handler    (chain_to_handler),
    .skip_context_save   (skip_context_save),
    .context_suspect     (context_suspect)
);

// ===== verification/mfsc_core_model.sv
// Purpose: core and checker side issuing accesses with verdicts
// Assumes: one access per call, one cycle long
// Notes: address is inverted once released so stale values never match
`timescale 1ns/1ps
module mfsc_core_model (
    // clock
    input  wire        clk,
    // accesses and verdicts
    output wire        fetch_req,
    output wire        fetch_no_exec,
    output wire        fetch_execute_never,
    output wire        data_req,
    output wire        data_forbidden,
    output wire        push_req,
    output wire        push_fault,
    output wire        pop_req,
    output wire        pop_fault,
    output reg  [31:0] data_address
);
    reg [8:0] ev = 9'h000;
    initial data_address = 32'h0000_0000;
    assign {fetch_req, fetch_no_exec, fetch_execute_never, data_req, data_forbidden,
            push_req, push_fault, pop_req, pop_fault} = ev;
    task fire(input [8:0] v, input [31:0] a);
        @(posedge clk);
        ev <= v;
        data_address <= a;
        @(posedge clk);
        ev <= 9'h000;
        data_address <= ~a;
    endtask
endmodule // mfsc_core_model

// ===== verification/mfsc_top_tb.sv
// Purpose: register-level test of the fault status byte
// Assumes: read data stands in the cycle after the strobe
// Notes: event codes follow the model's verdict order
`timescale 1ns/1ps
module mfsc_top_tb;
    reg         clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, unit_enable = 0;
    reg  [3:0]  reg_addr = 4'h0;
    reg  [31:0] reg_wdata = 32'h0000_0000;
    wire [31:0] reg_rdata, data_address;
    wire        fetch_req, fetch_no_exec, fetch_execute_never, data_req, data_forbidden;
    wire        push_req, push_fault, pop_req, pop_fault, irq;
    int         err_count = 0, compares = 0, cyc = 0;
    mfsc_top dut (.*, .fault_taken(), .pc_at_faulting(), .sp_adjust(), .chain_to_handler(),
                  .skip_context_save(), .context_suspect());
    mfsc_core_model core (.*);
    always #12.5 clk = ~clk;
    task chk(input [31:0] s, input [31:0] e);
        compares++;
        if (s !== e) begin
            err_count++;
            $display("wrong value at %0t: got %h want %h", $time, s, e);
        end
    endtask
    task wr(input [3:0] a, input [31:0] v);
        @(posedge clk);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 0;
    endtask
    task rd(input [3:0] a, input [31:0] e);
        @(posedge clk);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 0;
        #1 chk(reg_rdata, e);
    endtask
    task test_done;
        $display("compares %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // whole run needs well under 400 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            err_count++;
            test_done;
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1;
        rd(4'h0, 32'h0000_0000);
        $display("reset test done");
        @(posedge clk) unit_enable <= 1;
        core.fire(9'h030, 32'h1234_5678);
        rd(4'h0, 32'h0000_0082);
        rd(4'h1, 32'h1234_5678);
        wr(4'h0, 32'h0000_0000);
        rd(4'h0, 32'h0000_0082);
        wr(4'h0, 32'h0000_0082);
        core.fire(9'h180, 32'h0000_0040);
        core.fire(9'h00c, 32'h0000_0044);
        core.fire(9'h003, 32'h0000_0048);
        rd(4'h0, 32'h0000_0019);
        rd(4'h1, 32'h1234_5678);
        wr(4'h0, 32'h0000_00ff);
        rd(4'h0, 32'h0000_0000);
        $display("capture test done");
        @(posedge clk) unit_enable <= 0;
        core.fire(9'h030, 32'h0000_0050);
        core.fire(9'h140, 32'h0000_0054);
        rd(4'h0, 32'h0000_0001);
        $display("disabled unit test done");
        @(posedge clk) unit_enable <= 1;
        rd(4'h2, 32'h0000_001b);
        wr(4'h3, 32'h0000_0002);
        core.fire(9'h180, 32'h0000_0060);
        #1 chk(irq, 0);
        core.fire(9'h030, 32'h0000_0abc);
        #1 chk(irq, 1);
        rd(4'h2, 32'h0000_0003);
        chk(irq, 0);
        rd(4'hf, 32'h0000_0000);
        $display("interrupt test done");
        test_done;
    end
endmodule // mfsc_top_tb
